/* File: inc/enc_trig_consts.svh */
// Offsets, field positions, reset values and counts for the encoder trigger block.
// Assumes a 32-bit register port with one-cycle read latency.
`ifndef ENC_TRIG_CONSTS_SVH
`define ENC_TRIG_CONSTS_SVH

`define ET_NUM_CH        3
`define ET_CNT_W         32

`define ET_OFF_CTRL      8'h00
`define ET_OFF_STATUS    8'h04
`define ET_OFF_IRQ_EN    8'h08
`define ET_OFF_IRQ_CLR   8'h0C
`define ET_OFF_PERIOD    8'h10
`define ET_OFF_RD_REQ    8'h14
`define ET_OFF_RD_DATA   8'h18
`define ET_OFF_CH_CFG0   8'h20
`define ET_OFF_CMP0      8'h30
`define ET_OFF_LATCH0    8'h40
`define ET_OFF_COUNT0    8'h50

// Control fields
`define ET_CTRL_RUN      0
`define ET_CTRL_SRC_LSB  1
`define ET_CTRL_SRC_MSB  2

// Channel config fields
`define ET_CFG_CMP_EN    0
`define ET_CFG_MOD_EN    1
`define ET_CFG_IDX_FALL  2
`define ET_CFG_IDX_ACQ   3
`define ET_CFG_IDX_SYN   4
`define ET_CFG_IDX_CLR   5

// Status bits
`define ET_ST_ACQ        0
`define ET_ST_CMP        1
`define ET_ST_IDX        2
`define ET_ST_W          3

`define ET_CTRL_RST      32'h0000_0000
`define ET_CFG_RST       8'h00
`define ET_PERIOD_RST    32'h0000_0000

`endif

/* File: inc/enc_trig_pkg.sv */
// Types for the encoder trigger block.
// Assumes enc_trig_consts.svh is on the include path.
package enc_trig_pkg;
	typedef enum logic [1:0] {
		SRC_EXT,
		SRC_SYNC,
		SRC_TIMER,
		SRC_NONE
	} trig_src_t;
	typedef enum logic [1:0] {
		QD_IDLE,
		QD_UP,
		QD_DOWN
	} step_t;
endpackage : enc_trig_pkg

/* File: hw/enc_channel.sv */
// One encoder channel: quadrature decode, 32-bit count, compare and index.
// Assumes A, B and index are synchronous to clk_in.
`include "enc_trig_consts.svh"

module enc_channel (
	// Clock and reset
	input  wire logic                  clk_in,
	input  wire logic                  resetn_in,
	input  wire logic                  ce_in,
	// Encoder tracks
	input  wire logic                  a_in,
	input  wire logic                  b_in,
	input  wire logic                  idx_in,
	// Configuration
	input  wire logic [7:0]            cfg_in,
	input  wire logic [`ET_CNT_W-1:0]  cmp_in,
	// Results
	output logic      [`ET_CNT_W-1:0]  count_out,
	output logic                       cmp_hit_out,
	output logic                       idx_evt_out
);
	logic [1:0]            ab_q;
	logic                  idx_q;
	logic [`ET_CNT_W-1:0]  count_q;
	logic [`ET_CNT_W-1:0]  count_d;
	logic [`ET_CNT_W-1:0]  mod_q;
	logic [`ET_CNT_W-1:0]  mod_d;
	logic                  match_q;
	logic                  match_d;
	logic                  idx_evt;
	enc_trig_pkg::step_t   step;

	always_comb begin
		step = enc_trig_pkg::QD_IDLE;
		case ({ab_q, a_in, b_in})
			4'b0001, 4'b0111, 4'b1110, 4'b1000: step = enc_trig_pkg::QD_UP;
			4'b0010, 4'b1011, 4'b1101, 4'b0100: step = enc_trig_pkg::QD_DOWN;
			default: step = enc_trig_pkg::QD_IDLE;
		endcase
	end

	// Selected index edge
	assign idx_evt = cfg_in[`ET_CFG_IDX_FALL] ? (idx_q & ~idx_in) : (~idx_q & idx_in); // [R11]

	always_comb begin
		count_d = count_q;
		mod_d   = mod_q;
		case (step)
			enc_trig_pkg::QD_UP: begin
				count_d = count_q + 32'h0000_0001;
				mod_d   = (mod_q + 32'h0000_0001 >= cmp_in) ? 32'h0000_0000 : mod_q + 32'h0000_0001;
			end
			enc_trig_pkg::QD_DOWN: begin
				count_d = count_q - 32'h0000_0001;
				mod_d   = (mod_q == 32'h0000_0000) ? cmp_in - 32'h0000_0001 : mod_q - 32'h0000_0001;
			end
			default: begin
			end
		endcase
		if (idx_evt && cfg_in[`ET_CFG_IDX_CLR]) begin
			count_d = 32'h0000_0000; // [R12]
			mod_d   = 32'h0000_0000;
		end
	end

	// Match on present count, so the latch sees the matching value
	always_comb begin
		if (!cfg_in[`ET_CFG_CMP_EN]) begin
			match_d = 1'b0;
		end else if (cfg_in[`ET_CFG_MOD_EN]) begin
			match_d = (cmp_in != 32'h0000_0000) && (mod_q == 32'h0000_0000); // [R09]
		end else begin
			match_d = (count_q == cmp_in); // [R08]
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ab_q    <= 2'b00;
			idx_q   <= 1'b0;
			count_q <= 32'h0000_0000;
			mod_q   <= 32'h0000_0000;
			match_q <= 1'b0;
		end else if (ce_in) begin
			ab_q    <= {a_in, b_in};
			idx_q   <= idx_in;
			count_q <= count_d; // [R02]
			mod_q   <= mod_d;
			match_q <= match_d;
		end
	end

	assign count_out   = count_q;
	assign cmp_hit_out = ce_in & match_d & ~match_q; // [R13]
	assign idx_evt_out = ce_in & idx_evt;

	a_hit_single_pulse: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R13]
		cmp_hit_out |=> !cmp_hit_out)
		else $error("compare hit lasted more than one cycle");
	a_idx_clears_count: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R12]
		(ce_in && idx_evt && cfg_in[`ET_CFG_IDX_CLR]) |=> (count_q == 32'h0000_0000))
		else $error("index event did not clear count");
endmodule : enc_channel

/* File: hw/enc_trig_top.sv */
// Encoder trigger and acquisition top: three channels, triggers, capture, registers.
// Assumes a one-master register port and synchronous encoder and trigger pins.
//
// Added by the designer: the placing of the registers and the plain strobed port.
`include "enc_trig_consts.svh"

// Contract
// [R01] Three channels, each A, B, index
// [R02] Each channel holds 32-bit count
// [R03] On-demand read returns one channel only
// [R04] Software initialises inputs, then arms acquisition
// [R05] Trigger source external input or synchro line
// [R06] Synchro timer samples all channels periodically
// [R07] Captured set forwarded as soon as ready
// [R08] Compare equality raises synchro, latches count
// [R09] Modulo mode triggers at every multiple
// [R10] Compare trigger driven onto synchro line
// [R11] Selected index edge acquires or synchro-triggers
// [R12] Index clearing zeroes count on index
// [R13] One trigger pulse per match event
module enc_trig_top (
	// Clock and reset
	input  wire logic                          clk_in,
	input  wire logic                          resetn_in,
	input  wire logic                          ce_in,
	// Encoder tracks, one bit per channel
	input  wire logic [`ET_NUM_CH-1:0]         enc_a_in,
	input  wire logic [`ET_NUM_CH-1:0]         enc_b_in,
	input  wire logic [`ET_NUM_CH-1:0]         enc_idx_in,
	// Trigger pins
	input  wire logic                          ext_trig_in,
	input  wire logic                          sync_in,
	output logic                               sync_out,
	output logic                               sync_oe_out,
	// Captured set stream
	output logic                               set_valid_out,
	output logic [`ET_NUM_CH*`ET_CNT_W-1:0]    set_data_out,
	// Register port
	input  wire logic [7:0]                    addr_in,
	input  wire logic [31:0]                   wdata_in,
	input  wire logic                          wr_in,
	input  wire logic                          rd_in,
	output logic [31:0]                        rdata_out,
	// Interrupt
	output logic                               irq_out
);
	logic [31:0]                 ctrl_q;
	logic [31:0]                 period_q;
	logic [7:0]                  cfg_q   [`ET_NUM_CH];
	logic [`ET_CNT_W-1:0]        cmp_q   [`ET_NUM_CH];
	logic [`ET_CNT_W-1:0]        latch_q [`ET_NUM_CH];
	logic [`ET_CNT_W-1:0]        count   [`ET_NUM_CH];
	logic [`ET_CNT_W-1:0]        rd_sel_q;
	logic [`ET_NUM_CH-1:0]       cmp_hit;
	logic [`ET_NUM_CH-1:0]       idx_evt;
	logic [`ET_ST_W-1:0]         status_q;
	logic [`ET_ST_W-1:0]         irq_en_q;
	logic [31:0]                 timer_q;
	logic [31:0]                 rdata_q;
	logic                        ext_q;
	logic                        sync_q;
	logic                        sync_drive_q;
	logic                        timer_tick;
	logic                        src_trig;
	logic                        idx_acq;
	logic                        idx_sync;
	logic                        cmp_any;
	logic                        capture;
	logic                        run;
	logic                        set_valid_q;
	logic [`ET_NUM_CH*`ET_CNT_W-1:0] set_data_q;
	enc_trig_pkg::trig_src_t     src;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	function automatic logic [1:0] ch_of(input logic [7:0] a, input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		ch_of = d[3:2];
	endfunction : ch_of

	function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		in_bank = (a >= base) && (d[7:4] == 4'h0) && (d[3:2] < 2'(`ET_NUM_CH)) && (d[1:0] == 2'b00);
	endfunction : in_bank

	assign run = ctrl_q[`ET_CTRL_RUN];
	assign src = enc_trig_pkg::trig_src_t'(ctrl_q[`ET_CTRL_SRC_MSB:`ET_CTRL_SRC_LSB]);

	// Channels
	genvar gi;
	generate
		for (gi = 0; gi < `ET_NUM_CH; gi++) begin : g_ch
			enc_channel u_ch ( // [R01]
				.clk_in      (clk_in),
				.resetn_in   (resetn_in),
				.ce_in       (ce_in),
				.a_in        (enc_a_in[gi]),
				.b_in        (enc_b_in[gi]),
				.idx_in      (enc_idx_in[gi]),
				.cfg_in      (cfg_q[gi]),
				.cmp_in      (cmp_q[gi]),
				.count_out   (count[gi]),
				.cmp_hit_out (cmp_hit[gi]),
				.idx_evt_out (idx_evt[gi])
			);
		end
	endgenerate

	// Index actions
	always_comb begin
		idx_acq  = 1'b0;
		idx_sync = 1'b0;
		for (int i = 0; i < `ET_NUM_CH; i++) begin
			idx_acq  = idx_acq  | (idx_evt[i] & cfg_q[i][`ET_CFG_IDX_ACQ]); // [R11]
			idx_sync = idx_sync | (idx_evt[i] & cfg_q[i][`ET_CFG_IDX_SYN]); // [R11]
		end
	end

	assign cmp_any = |cmp_hit;

	// Trigger pins edge detect
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ext_q  <= 1'b0;
			sync_q <= 1'b0;
		end else if (ce_in) begin
			ext_q  <= ext_trig_in;
			sync_q <= sync_in;
		end
	end

	// Synchro timer
	assign timer_tick = ce_in && run && (src == enc_trig_pkg::SRC_TIMER)
		&& (period_q != 32'h0000_0000) && (timer_q >= period_q - 32'h0000_0001);

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			timer_q <= 32'h0000_0000;
		end else if (ce_in) begin
			if (!run || src != enc_trig_pkg::SRC_TIMER || timer_tick) begin
				timer_q <= 32'h0000_0000;
			end else begin
				timer_q <= timer_q + 32'h0000_0001;
			end
		end
	end

	// Source selection
	always_comb begin
		case (src)
			enc_trig_pkg::SRC_EXT:   src_trig = ext_trig_in & ~ext_q; // [R05]
			enc_trig_pkg::SRC_SYNC:  src_trig = sync_in & ~sync_q; // [R05]
			enc_trig_pkg::SRC_TIMER: src_trig = timer_tick; // [R06]
			default:                 src_trig = 1'b0;
		endcase
	end

	// Acquisition happens only once armed by software
	assign capture = ce_in & run & (src_trig | idx_acq); // [R04]

	// Synchro line drive: one-cycle pulse
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sync_drive_q <= 1'b0;
		end else if (ce_in) begin
			sync_drive_q <= cmp_any | idx_sync; // [R10]
		end
	end
	assign sync_out    = sync_drive_q;
	assign sync_oe_out = sync_drive_q;

	// Compare latch per channel, and captured set stream
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < `ET_NUM_CH; i++) begin
				latch_q[i] <= 32'h0000_0000;
			end
			set_valid_q <= 1'b0;
			set_data_q  <= '0;
		end else if (ce_in) begin
			for (int i = 0; i < `ET_NUM_CH; i++) begin
				if (cmp_hit[i]) begin
					latch_q[i] <= count[i]; // [R08]
				end
			end
			set_valid_q <= capture;
			if (capture) begin
				for (int i = 0; i < `ET_NUM_CH; i++) begin
					set_data_q[i*`ET_CNT_W +: `ET_CNT_W] <= count[i]; // [R06]
				end
			end
		end
	end
	assign set_valid_out = set_valid_q; // [R07]
	assign set_data_out  = set_data_q;

	// Register writes
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctrl_q   <= `ET_CTRL_RST;
			period_q <= `ET_PERIOD_RST;
			irq_en_q <= '0;
			for (int i = 0; i < `ET_NUM_CH; i++) begin
				cfg_q[i] <= `ET_CFG_RST;
				cmp_q[i] <= 32'h0000_0000;
			end
		end else if (ce_in && wr_in) begin
			if (hit(addr_in, `ET_OFF_CTRL)) begin
				ctrl_q <= wdata_in;
			end
			if (hit(addr_in, `ET_OFF_PERIOD)) begin
				period_q <= wdata_in;
			end
			if (hit(addr_in, `ET_OFF_IRQ_EN)) begin
				irq_en_q <= wdata_in[`ET_ST_W-1:0];
			end
			if (in_bank(addr_in, `ET_OFF_CH_CFG0)) begin
				cfg_q[ch_of(addr_in, `ET_OFF_CH_CFG0)] <= wdata_in[7:0];
			end
			if (in_bank(addr_in, `ET_OFF_CMP0)) begin
				cmp_q[ch_of(addr_in, `ET_OFF_CMP0)] <= wdata_in;
			end
		end
	end

	// On-demand single channel snapshot
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rd_sel_q <= 32'h0000_0000;
		end else if (ce_in && wr_in && hit(addr_in, `ET_OFF_RD_REQ)
			&& wdata_in[1:0] < 2'(`ET_NUM_CH)) begin
			rd_sel_q <= count[wdata_in[1:0]]; // [R03]
		end
	end

	// Sticky status, set wins over clear
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			status_q <= '0;
		end else if (ce_in) begin
			for (int i = 0; i < `ET_ST_W; i++) begin
				if (wr_in && hit(addr_in, `ET_OFF_IRQ_CLR) && wdata_in[i]) begin
					status_q[i] <= 1'b0;
				end
			end
			if (capture) begin
				status_q[`ET_ST_ACQ] <= 1'b1;
			end
			if (cmp_any) begin
				status_q[`ET_ST_CMP] <= 1'b1;
			end
			if (|idx_evt) begin
				status_q[`ET_ST_IDX] <= 1'b1;
			end
		end
	end
	assign irq_out = |(status_q & irq_en_q);

	// Register reads
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_q <= 32'h0000_0000;
		end else if (ce_in) begin
			rdata_q <= 32'h0000_0000;
			if (rd_in) begin
				if (hit(addr_in, `ET_OFF_CTRL)) begin
					rdata_q <= ctrl_q;
				end else if (hit(addr_in, `ET_OFF_STATUS)) begin
					rdata_q <= {{(32-`ET_ST_W){1'b0}}, status_q};
				end else if (hit(addr_in, `ET_OFF_IRQ_EN)) begin
					rdata_q <= {{(32-`ET_ST_W){1'b0}}, irq_en_q};
				end else if (hit(addr_in, `ET_OFF_PERIOD)) begin
					rdata_q <= period_q;
				end else if (hit(addr_in, `ET_OFF_RD_DATA)) begin
					rdata_q <= rd_sel_q; // [R03]
				end else if (in_bank(addr_in, `ET_OFF_CH_CFG0)) begin
					rdata_q <= {24'h00_0000, cfg_q[ch_of(addr_in, `ET_OFF_CH_CFG0)]};
				end else if (in_bank(addr_in, `ET_OFF_CMP0)) begin
					rdata_q <= cmp_q[ch_of(addr_in, `ET_OFF_CMP0)];
				end else if (in_bank(addr_in, `ET_OFF_LATCH0)) begin
					rdata_q <= latch_q[ch_of(addr_in, `ET_OFF_LATCH0)];
				end else if (in_bank(addr_in, `ET_OFF_COUNT0)) begin
					rdata_q <= count[ch_of(addr_in, `ET_OFF_COUNT0)];
				end
			end
		end
	end
	assign rdata_out = rdata_q;

	// Checks
	a_cmp_drives_sync: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R10]
		(ce_in && cmp_any) |=> (sync_out && sync_oe_out))
		else $error("compare hit not driven onto synchro line");
	a_cmp_latches: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R08]
		(ce_in && cmp_hit[0]) |=> (latch_q[0] == $past(count[0])))
		else $error("compare hit did not latch count");
	a_capture_forward: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R07]
		capture |=> (set_valid_out && set_data_out[`ET_CNT_W-1:0] == $past(count[0])))
		else $error("captured set not forwarded next cycle");
	a_timer_period: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R06]
		(timer_tick && ce_in) |=> (timer_q == 32'h0000_0000))
		else $error("synchro timer did not restart");
	a_ext_source: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R05]
		(ce_in && run && src == enc_trig_pkg::SRC_EXT && ext_trig_in && !ext_q)
		|=> set_valid_out)
		else $error("external trigger edge did not capture");
	a_no_arm_no_set: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R04]
		(ce_in && !run) |=> !set_valid_out)
		else $error("capture while not armed");
	a_rd_one_chan: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R03]
		(ce_in && wr_in && hit(addr_in, `ET_OFF_RD_REQ) && wdata_in[1:0] == 2'b01)
		|=> (rd_sel_q == $past(count[1])))
		else $error("on-demand read took wrong channel");
	a_idx_sync: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R11]
		(ce_in && idx_sync) |=> sync_out)
		else $error("index synchro not driven");

	// Trigger sources, snapshot read and sticky status
	a_sync_source: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R05]
		(ce_in && run && src == enc_trig_pkg::SRC_SYNC && sync_in && !sync_q)
		|=> set_valid_out)
		else $error("synchro edge did not capture");
	a_timer_capture: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R06]
		timer_tick |=> set_valid_out)
		else $error("synchro timer expiry did not capture");
	a_idx_acquires: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R11]
		(ce_in && run && idx_acq) |=> set_valid_out)
		else $error("index edge did not start acquisition");
	a_rd_data_path: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R03]
		(ce_in && rd_in && hit(addr_in, `ET_OFF_RD_DATA))
		|=> (rdata_out == $past(rd_sel_q)))
		else $error("snapshot read returned wrong value");
	a_acq_status: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R07]
		capture |=> status_q[`ET_ST_ACQ])
		else $error("capture did not set status");
	a_cmp_status: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R08]
		(ce_in && cmp_any) |=> status_q[`ET_ST_CMP])
		else $error("compare hit did not set status");
	a_idx_status: assert property (@(posedge clk_in) disable iff (!resetn_in) // [R11]
		(|idx_evt) |=> status_q[`ET_ST_IDX])
		else $error("index event did not set status");
endmodule : enc_trig_top

/* File: verif/enc_model.sv */
// Incremental encoder model: quadrature tracks and index for three channels.
// Assumes the bench requests one step per channel at most every two cycles.
module enc_model (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	// Step requests
	input  wire logic [2:0]  step_in,
	input  wire logic [2:0]  up_in,
	input  wire logic [2:0]  idx_req_in,
	// Encoder tracks
	output logic      [2:0]  a_out,
	output logic      [2:0]  b_out,
	output logic      [2:0]  idx_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph_q [3];
	// Phase walk, B leads A when counting up
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ph_q <= '{2'h0, 2'h0, 2'h0};
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (step_in[i]) begin
					ph_q[i] <= up_in[i] ? ph_q[i] + 2'h1 : ph_q[i] - 2'h1;
				end
			end
		end
	end
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			idx_out <= 3'h0;
		end else begin
			idx_out <= idx_req_in;
		end
	end
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			a_out[i] = ph_q[i][1];
			b_out[i] = (ph_q[i] == 2'h1) || (ph_q[i] == 2'h2);
		end
	end
endmodule : enc_model

/* File: verif/testbench.sv */
// Self-checking bench: register port, encoder model, trigger pins, capture stream.
// Assumes the design constants header is on the include path.
`include "enc_trig_consts.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
	$display("Error %s exp %0h got %0h", n, e, g); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in, resetn_in, ext_trig_in, sync_in, wr_in, rd_in, ce_in;
	logic        sync_out, sync_oe_out, set_valid_out, irq_out;
	logic [2:0]  step, up, idx_req, enc_a, enc_b, enc_idx;
	logic [7:0]  addr_in;
	logic [31:0] wdata_in, rdata_out, c;
	logic [95:0] set_data_out;
	int          cnt[3];
	int          n_fail, checks_done, n_sync, n_valid;
	enc_model i_enc (.clk_in(clk_in), .resetn_in(resetn_in), .step_in(step), .up_in(up),
		.idx_req_in(idx_req), .a_out(enc_a), .b_out(enc_b), .idx_out(enc_idx));
	enc_trig_top i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
		.enc_a_in(enc_a), .enc_b_in(enc_b), .enc_idx_in(enc_idx),
		.ext_trig_in(ext_trig_in), .sync_in(sync_in), .sync_out(sync_out),
		.sync_oe_out(sync_oe_out), .set_valid_out(set_valid_out),
		.set_data_out(set_data_out), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	task automatic final_report();
		if (n_fail == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
		#1;
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		`CHK("rdata", e, rdata_out)
	endtask : rchk
	task automatic stp(input int ch, input logic u);
		@(posedge clk_in);
		step[ch] <= 1'b1;
		up[ch] <= u;
		@(posedge clk_in);
		step[ch] <= 1'b0;
		repeat (2) @(posedge clk_in);
		cnt[ch] = u ? cnt[ch] + 1 : cnt[ch] - 1;
	endtask : stp
	task automatic idxp(input int ch);
		@(posedge clk_in);
		idx_req[ch] <= 1'b1;
		repeat (3) @(posedge clk_in);
		idx_req[ch] <= 1'b0;
		repeat (5) @(posedge clk_in);
	endtask : idxp
	task automatic pin(input logic which);
		@(posedge clk_in);
		if (which) sync_in <= 1'b1; else ext_trig_in <= 1'b1;
		@(posedge clk_in);
		if (which) sync_in <= 1'b0; else ext_trig_in <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask : pin
	// Synchro pulses and captured sets
	always @(negedge clk_in) begin
		if (sync_out === 1'b1) begin
			n_sync++;
			`CHK("sync_oe", 1'b1, sync_oe_out)
		end
		if (set_valid_out === 1'b1) begin
			n_valid++;
			for (int i = 0; i < 3; i++) `CHK("set", cnt[i], set_data_out[32*i+:32])
		end
	end
	initial begin
		#400000;
		n_fail++;
		final_report();
	end
	initial begin
		{resetn_in, ext_trig_in, sync_in, wr_in, rd_in} = 5'h00;
		ce_in = 1'b1;
		{step, up, idx_req, addr_in, wdata_in} = '0;
		cnt = '{0, 0, 0};
		void'($urandom(32'h8ba2));
		repeat (20) @(posedge clk_in);
		resetn_in <= 1'b1;
		rchk(`ET_OFF_CTRL, `ET_CTRL_RST);
		rchk(`ET_OFF_PERIOD, `ET_PERIOD_RST);
		rchk(`ET_OFF_STATUS, 32'h0000_0000);
		rchk(8'hFC, 32'h0000_0000);
		repeat (40) stp($urandom % 3, ($urandom % 4) != 0);
		for (int i = 0; i < 3; i++) rchk(`ET_OFF_COUNT0 + 4 * i, cnt[i]);
		for (int i = 0; i < 3; i++) begin
			wr(`ET_OFF_RD_REQ, i);
			rchk(`ET_OFF_RD_DATA, cnt[i]);
		end
		for (int s = 0; s < 2; s++) begin
			n_valid = 0;
			wr(`ET_OFF_CTRL, 32'h0000_0001 | (s << 1));
			pin(!s);
			`CHK("wrong_src", 0, n_valid)
			pin(s);
			`CHK("src", 1, n_valid)
		end
		wr(`ET_OFF_PERIOD, 32'h0000_0005);
		n_valid = 0;
		wr(`ET_OFF_CTRL, 32'h0000_0005);
		repeat (50) @(posedge clk_in);
		wr(`ET_OFF_CTRL, 32'h0000_0000);
		`CHK("timer", 1, (n_valid >= 9 && n_valid <= 12))
		// Strobe ignored while clock enable is low
		@(posedge clk_in);
		ce_in <= 1'b0;
		wr(`ET_OFF_PERIOD, 32'h0000_0009);
		ce_in <= 1'b1;
		rchk(`ET_OFF_PERIOD, 32'h0000_0005);
		wr(`ET_OFF_IRQ_EN, 32'h0000_0000);
		`CHK("irq_mask", 1'b0, irq_out)
		wr(`ET_OFF_IRQ_EN, 32'h0000_0007);
		`CHK("irq_on", 1'b1, irq_out)
		wr(`ET_OFF_IRQ_CLR, 32'h0000_0007);
		`CHK("irq_clr", 1'b0, irq_out)
		c = cnt[0] + 2;
		wr(`ET_OFF_CMP0, c);
		wr(`ET_OFF_CH_CFG0, 32'h0000_0001);
		n_sync = 0;
		stp(0, 1'b1);
		stp(0, 1'b1);
		repeat (10) @(posedge clk_in);
		`CHK("cmp_sync", 1, n_sync)
		rchk(`ET_OFF_LATCH0, c);
		rchk(`ET_OFF_STATUS, 32'h0000_0002);
		`CHK("irq_cmp", 1'b1, irq_out)
		wr(`ET_OFF_CH_CFG0, 32'h0000_0000);
		wr(`ET_OFF_IRQ_CLR, 32'h0000_0007);
		wr(`ET_OFF_CH_CFG0 + 4, 32'h0000_0030);
		n_sync = 0;
		idxp(1);
		cnt[1] = 0;
		rchk(`ET_OFF_COUNT0 + 4, 32'h0000_0000);
		`CHK("idx_sync", 1, n_sync)
		rchk(`ET_OFF_STATUS, 32'h0000_0004);
		wr(`ET_OFF_CMP0 + 4, 32'h0000_0004);
		wr(`ET_OFF_CH_CFG0 + 4, 32'h0000_0003);
		stp(1, 1'b1);
		n_sync = 0;
		repeat (11) stp(1, 1'b1);
		repeat (4) @(posedge clk_in);
		`CHK("mod_sync", 3, n_sync)
		rchk(`ET_OFF_COUNT0 + 4, cnt[1]);
		wr(`ET_OFF_CH_CFG0 + 4, 32'h0000_0000);
		wr(`ET_OFF_CH_CFG0 + 8, 32'h0000_000C);
		wr(`ET_OFF_CTRL, 32'h0000_0007);
		n_valid = 0;
		idxp(2);
		`CHK("idx_acq", 1, n_valid)
		wr(`ET_OFF_CTRL, 32'h0000_0000);
		final_report();
	end
endmodule : testbench
